// ---- src/lcb_consts.svh ----
`ifndef LCB_CONSTS_SVH
`define LCB_CONSTS_SVH

// geometry of the attached part
`define LCB_NBANK     8
`define LCB_BANK_W    3
`define LCB_CNT_W     8

// command clock period
`define LCB_CLK_NS    100

// least times in ns, rounded up to whole clock cycles below
`define LCB_TRCD_NS   18
`define LCB_TRP_NS    21
`define LCB_TRRD_NS   10
`define LCB_TWR_NS    15
`define LCB_TRFCPB_NS 90
`define LCB_TRFCAB_NS 130
`define LCB_TXSR_NS   140
`define LCB_TINIT5_NS 10000

`define LCB_CYC(ns) (((ns) + `LCB_CLK_NS - 1) / `LCB_CLK_NS)

`define LCB_TRCD_CYC   `LCB_CYC(`LCB_TRCD_NS)
`define LCB_TRP_CYC    `LCB_CYC(`LCB_TRP_NS)
`define LCB_TRRD_CYC   `LCB_CYC(`LCB_TRRD_NS)
`define LCB_TWR_CYC    `LCB_CYC(`LCB_TWR_NS)
`define LCB_TRFCPB_CYC `LCB_CYC(`LCB_TRFCPB_NS)
`define LCB_TRFCAB_CYC `LCB_CYC(`LCB_TRFCAB_NS)
`define LCB_TXSR_CYC   `LCB_CYC(`LCB_TXSR_NS)
`define LCB_TINIT5_CYC `LCB_CYC(`LCB_TINIT5_NS)

// delays given directly in clock cycles
`define LCB_TMRR_CYC   2
`define LCB_TMRW_CYC   5
`define LCB_BURST_CYC  2

`endif

// ---- src/lcb_pkg.sv ----
`default_nettype none
package lcb_pkg;

	// request and pin command codes; srx is local, never driven to the pins
	typedef enum logic [3:0] {
		LCB_NOP    = 4'h0,
		LCB_ACT    = 4'h1,
		LCB_RD     = 4'h2,
		LCB_WR     = 4'h3,
		LCB_PRE    = 4'h4,
		LCB_REF_PB = 4'h5,
		LCB_REF_AB = 4'h6,
		LCB_SRE    = 4'h7,
		LCB_SRX    = 4'h8,
		LCB_MRW    = 4'h9,
		LCB_MRR    = 4'hA,
		LCB_BST    = 4'hB,
		LCB_RST    = 4'hC
	} lcb_cmd_t;

	// per-bank state as the controller believes it
	typedef enum logic [3:0] {
		BK_PWR_ON  = 4'h0,
		BK_RESET   = 4'h1,
		BK_IDLE    = 4'h2,
		BK_ROW_ACT = 4'h3,
		BK_ACTIVE  = 4'h4,
		BK_READ    = 4'h5,
		BK_WRITE   = 4'h6,
		BK_RD_AP   = 4'h7,
		BK_WR_AP   = 4'h8,
		BK_PRECHG  = 4'h9,
		BK_REFR    = 4'hA
	} lcb_bank_st_t;

endpackage
`default_nettype wire

// ---- src/lcb_bank_track.sv ----
`include "lcb_consts.svh"
`default_nettype none
module lcb_bank_track
	import lcb_pkg::*;
(
	input  wire logic   clock_i,
	input  wire logic   rst_i,
	input  wire logic   go_i,
	input  wire lcb_cmd_t cmd_i,
	input  wire logic   ap_i,
	output var lcb_bank_st_t state_o
);

	lcb_bank_st_t             state_reg;
	lcb_bank_st_t             state_next;
	logic [`LCB_CNT_W-1:0]    cnt_reg;
	logic [`LCB_CNT_W-1:0]    cnt_next;
	wire                      cnt_zero = (cnt_reg == '0);

	assign state_o = state_reg;

	// timed states settle when their count runs out; a command then overrides
	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_zero ? cnt_reg : cnt_reg - 1'b1;
		unique case (state_reg)
			BK_ROW_ACT, BK_READ, BK_WRITE:
				if (cnt_zero) state_next = BK_ACTIVE;
			BK_RD_AP, BK_WR_AP, BK_PRECHG, BK_REFR, BK_RESET:
				if (cnt_zero) state_next = BK_IDLE;
			BK_PWR_ON, BK_IDLE, BK_ACTIVE: ;
			default: state_next = BK_PWR_ON;
		endcase
		// no go on nop, so the bank just carries on
		if (go_i)
		begin
			unique case (cmd_i)
				LCB_ACT:
				begin
					state_next = BK_ROW_ACT;
					cnt_next = `LCB_CNT_W'(`LCB_TRCD_CYC);
				end
				// auto precharge lengthens the burst state and settles the bank to idle, not active
				LCB_RD:
				begin
					state_next = ap_i ? BK_RD_AP : BK_READ;
					cnt_next = ap_i
						? `LCB_CNT_W'(`LCB_BURST_CYC + `LCB_TRP_CYC)
						: `LCB_CNT_W'(`LCB_BURST_CYC);
				end
				LCB_WR:
				begin
					state_next = ap_i ? BK_WR_AP : BK_WRITE;
					cnt_next = ap_i
						? `LCB_CNT_W'(`LCB_BURST_CYC + `LCB_TWR_CYC
							+ `LCB_TRP_CYC)
						: `LCB_CNT_W'(`LCB_BURST_CYC);
				end
				LCB_PRE:
				begin
					state_next = BK_PRECHG;
					cnt_next = `LCB_CNT_W'(`LCB_TRP_CYC);
				end
				LCB_BST:
				begin
					state_next = BK_ACTIVE;
					cnt_next = '0;
				end
				LCB_REF_PB:
				begin
					state_next = BK_REFR;
					cnt_next = `LCB_CNT_W'(`LCB_TRFCPB_CYC);
				end
				LCB_REF_AB:
				begin
					state_next = BK_REFR;
					cnt_next = `LCB_CNT_W'(`LCB_TRFCAB_CYC);
				end
				LCB_RST:
				begin
					state_next = BK_RESET;
					cnt_next = `LCB_CNT_W'(`LCB_TINIT5_CYC);
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			state_reg <= BK_PWR_ON;
			cnt_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

endmodule
`default_nettype wire

// ---- src/lcb_host.sv ----
// Contract
// - commands only after clock enable high on two edges and exit time met
// - never drive a bank state and command pair outside the legal set
// - all-bank refresh, self refresh entry, mode write only with all banks idle
// - burst terminate goes to the bursting bank, which returns to active
// - burst terminate only while a read or write burst is running
// - only nop during mode register read or write delay
// - keep activate to activate spacing between banks
// - reads and writes with or without auto precharge, same moves
// - precharge one or all banks; all needs every bank prechargeable
// - write after read only once the read burst is over
// - read after write only once the write burst is over
// - other banks stay usable while one bank runs auto precharge
// - reset from power on, sent as mode write with all banks idle
// - a settling bank gets nothing but nop or allowed commands
`include "lcb_consts.svh"
`default_nettype none
module lcb_host
	import lcb_pkg::*;
(
	input  wire logic                   clock_i,
	input  wire logic                   rst_i,
	input  wire logic                   req_valid_i,
	input  wire lcb_cmd_t               req_cmd_i,
	input  wire logic [`LCB_BANK_W-1:0] req_bank_i,
	input  wire logic                   req_ap_i,
	input  wire logic                   req_all_i,
	output logic                        req_ready_o,
	output logic                        req_reject_o,
	output var lcb_cmd_t                cmd_o,
	output logic [`LCB_BANK_W-1:0]      bank_o,
	output logic                        ap_o,
	output logic                        all_o,
	output logic                        cke_o,
	output logic                        mr_busy_o
);

	lcb_bank_st_t                bank_st [`LCB_NBANK];
	logic [`LCB_NBANK-1:0]       go_v;
	logic [`LCB_NBANK-1:0]       idle_v;
	logic [`LCB_NBANK-1:0]       pwr_v;
	logic [`LCB_NBANK-1:0]       preok_v;

	lcb_cmd_t                    cmd_reg;
	logic [`LCB_BANK_W-1:0]      bank_reg;
	logic                        ap_reg;
	logic                        all_reg;
	logic                        cke_reg;
	logic                        cke_prev_reg;
	logic                        sr_reg;
	logic [`LCB_CNT_W-1:0]       xsr_reg;
	logic [`LCB_CNT_W-1:0]       rrd_reg;
	logic [`LCB_CNT_W-1:0]       mr_reg;
	logic [`LCB_CNT_W-1:0]       burst_reg;
	logic [`LCB_BANK_W-1:0]      burst_bank_reg;
	logic                        burst_wr_reg;
	logic                        burst_ap_reg;

	// command decode
	wire is_nop = (req_cmd_i == LCB_NOP);
	wire is_act = (req_cmd_i == LCB_ACT);
	wire is_rd  = (req_cmd_i == LCB_RD);
	wire is_wr  = (req_cmd_i == LCB_WR);
	wire is_pre = (req_cmd_i == LCB_PRE);
	wire is_rpb = (req_cmd_i == LCB_REF_PB);
	wire is_rab = (req_cmd_i == LCB_REF_AB);
	wire is_sre = (req_cmd_i == LCB_SRE);
	wire is_srx = (req_cmd_i == LCB_SRX);
	wire is_mrw = (req_cmd_i == LCB_MRW);
	wire is_mrr = (req_cmd_i == LCB_MRR);
	wire is_bst = (req_cmd_i == LCB_BST);
	wire is_rst = (req_cmd_i == LCB_RST);
	wire is_known = is_nop | is_act | is_rd | is_wr | is_pre | is_rpb
		| is_rab | is_sre | is_srx | is_mrw | is_mrr | is_bst | is_rst;

	// global conditions
	wire burst_on = (burst_reg != '0);
	wire mr_busy  = (mr_reg != '0);
	wire all_idle = &idle_v;
	wire all_pwr  = &pwr_v;
	wire any_pwr  = |pwr_v;
	// a command needs clock enable high now and on the previous edge
	wire cke_ok = cke_reg & cke_prev_reg & (xsr_reg == '0)
		& ~sr_reg;
	wire gate = cke_ok & ~mr_busy;

	// state of the addressed bank alone; an idle other bank adds nothing
	wire lcb_bank_st_t tgt = bank_st[req_bank_i];
	wire t_idle = (tgt == BK_IDLE);
	wire t_pwr  = (tgt == BK_PWR_ON);
	wire t_rowa = (tgt == BK_ROW_ACT);
	wire t_open = (tgt == BK_ACTIVE) | (tgt == BK_READ)
		| (tgt == BK_WRITE);
	wire t_preok = t_idle | t_open;
	wire t_mrrok = t_idle | t_rowa | (tgt == BK_ACTIVE)
		| (tgt == BK_PRECHG) | (tgt == BK_RESET);

	// may go now: a burst on any bank blocks the opposite burst and all refresh, self refresh, mode and reset commands
	wire ok_act = t_idle & (rrd_reg == '0);
	wire ok_rd  = t_open & ~(burst_on & burst_wr_reg);
	wire ok_wr  = t_open & ~(burst_on & ~burst_wr_reg);
	wire ok_pre = req_all_i ? &preok_v : t_preok;
	wire ok_rpb = t_idle & ~burst_on;
	wire ok_glb = all_idle & ~burst_on;
	wire ok_rst = (all_idle | all_pwr) & ~burst_on;
	wire ok_mrr = t_mrrok & ~burst_on;
	wire ok_bst = burst_on & ~burst_ap_reg;

	// never legal in the present state: refused at once, not waited on
	wire bad_act = t_open | t_rowa | t_pwr;
	wire bad_rw  = ~(t_open | t_rowa);
	wire bad_pre = req_all_i ? any_pwr : t_pwr;
	wire bad_w = ~is_known
		| (is_act & bad_act)
		| ((is_rd | is_wr) & bad_rw)
		| (is_pre & bad_pre)
		| ((is_rpb | is_mrr) & t_pwr)
		| ((is_rab | is_sre | is_mrw) & any_pwr)
		| (is_bst & ~ok_bst)
		| (is_srx & ~sr_reg);

	wire ok_w = is_nop
		| (is_act & ok_act)
		| (is_rd & ok_rd)
		| (is_wr & ok_wr)
		| (is_pre & ok_pre)
		| (is_rpb & ok_rpb)
		| ((is_rab | is_sre | is_mrw) & ok_glb)
		| (is_rst & ok_rst)
		| (is_mrr & ok_mrr)
		| (is_bst & ok_bst);

	// nop always passes; srx is taken even while the clock enable is low
	wire grant = req_valid_i & ~bad_w
		& (is_nop | (is_srx ? sr_reg : gate & ok_w));
	wire issue = grant & ~is_nop & ~is_srx;
	wire all_bank = (is_pre & req_all_i) | is_rab | is_rst;
	// terminate always aims at the bank that owns the running burst
	wire [`LCB_BANK_W-1:0] hit_bank =
		is_bst ? burst_bank_reg : req_bank_i;

	assign req_ready_o  = grant;
	assign req_reject_o = req_valid_i & bad_w;
	assign cmd_o        = cmd_reg;
	assign bank_o       = bank_reg;
	assign ap_o         = ap_reg;
	assign all_o        = all_reg;
	assign cke_o        = cke_reg;
	assign mr_busy_o    = mr_busy;

	// one tracker per bank
	genvar b;
	generate
		for (b = 0; b < `LCB_NBANK; b++)
		begin : g_bank
			assign go_v[b] = issue
				& (all_bank | (hit_bank == `LCB_BANK_W'(b)));
			assign idle_v[b]  = (bank_st[b] == BK_IDLE);
			assign pwr_v[b]   = (bank_st[b] == BK_PWR_ON);
			assign preok_v[b] = (bank_st[b] == BK_IDLE)
				| (bank_st[b] == BK_ACTIVE)
				| (bank_st[b] == BK_READ)
				| (bank_st[b] == BK_WRITE);
			lcb_bank_track u_bank (
				.clock_i (clock_i),
				.rst_i   (rst_i),
				.go_i    (go_v[b]),
				.cmd_i   (req_cmd_i),
				.ap_i    (req_ap_i),
				.state_o (bank_st[b])
			);
		end
	endgenerate

	// pin command register; reset goes out as a mode write
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cmd_reg <= LCB_NOP;
			bank_reg <= '0;
			ap_reg <= 1'b0;
			all_reg <= 1'b0;
		end
		else
		begin
			cmd_reg <= issue ? (is_rst ? LCB_MRW : req_cmd_i) : LCB_NOP;
			bank_reg <= issue ? hit_bank : '0;
			ap_reg <= issue & (is_rd | is_wr) & req_ap_i;
			all_reg <= issue & is_pre & req_all_i;
		end
	end

	// clock enable and self refresh; exit time blocks commands after srx
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			cke_reg <= 1'b1;
			cke_prev_reg <= 1'b0;
			sr_reg <= 1'b0;
			xsr_reg <= '0;
		end
		else
		begin
			cke_prev_reg <= cke_reg;
			if (issue & is_sre)
			begin
				sr_reg <= 1'b1;
				cke_reg <= 1'b0;
			end
			else if (grant & is_srx)
			begin
				sr_reg <= 1'b0;
				cke_reg <= 1'b1;
				xsr_reg <= `LCB_CNT_W'(`LCB_TXSR_CYC);
			end
			else if (xsr_reg != '0)
				xsr_reg <= xsr_reg - 1'b1;
		end
	end

	// activate spacing and mode register delays
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			rrd_reg <= '0;
			mr_reg <= '0;
		end
		else
		begin
			if (issue & is_act)
				rrd_reg <= `LCB_CNT_W'(`LCB_TRRD_CYC);
			else if (rrd_reg != '0)
				rrd_reg <= rrd_reg - 1'b1;
			// banks keep settling on their own while this runs
			if (issue & is_mrr)
				mr_reg <= `LCB_CNT_W'(`LCB_TMRR_CYC);
			else if (issue & (is_mrw | is_rst))
				mr_reg <= `LCB_CNT_W'(`LCB_TMRW_CYC);
			else if (mr_busy)
				mr_reg <= mr_reg - 1'b1;
		end
	end

	// most recent burst; a new burst on any bank replaces it
	always_ff @(posedge clock_i)
	begin
		if (rst_i)
		begin
			burst_reg <= '0;
			burst_bank_reg <= '0;
			burst_wr_reg <= 1'b0;
			burst_ap_reg <= 1'b0;
		end
		else if (issue & (is_rd | is_wr))
		begin
			burst_reg <= `LCB_CNT_W'(`LCB_BURST_CYC);
			burst_bank_reg <= req_bank_i;
			burst_wr_reg <= is_wr;
			burst_ap_reg <= req_ap_i;
		end
		else if (issue & is_bst)
			burst_reg <= '0;
		else if (burst_on)
			burst_reg <= burst_reg - 1'b1;
	end

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	sequence s_mrr_quiet;
		(cmd_o == LCB_MRR) ##1 (cmd_o == LCB_NOP)[*2];
	endsequence
	sequence s_mrw_quiet;
		(cmd_o == LCB_MRW) ##1 (cmd_o == LCB_NOP)[*5];
	endsequence

	a_mrr_nop_hold: assert property (
		issue && is_mrr |=> s_mrr_quiet)
		else $error("command issued inside mode read delay");
	a_mrw_nop_hold: assert property (
		issue && (is_mrw || is_rst) |=> s_mrw_quiet)
		else $error("command issued inside mode write delay");
	a_bst_in_burst: assert property (
		issue && is_bst |-> burst_on && !burst_ap_reg)
		else $error("burst terminate without a running burst");
	a_bst_same_bank: assert property (
		issue && is_bst |=> bank_o == $past(burst_bank_reg)
			&& bank_st[bank_o] == BK_ACTIVE && !burst_on)
		else $error("burst terminate sent to the wrong bank");
	a_global_idle: assert property (
		issue && (is_rab || is_sre || is_mrw) |-> all_idle && !burst_on)
		else $error("all-bank command with a bank not idle");
	a_act_spacing: assert property (
		issue && is_act |=> !(issue && is_act))
		else $error("activates closer than their spacing");
	a_rw_turn: assert property (
		issue && (is_rd || is_wr) && burst_on
			|-> burst_wr_reg == is_wr)
		else $error("read write turnaround inside a burst");
	a_cke_two_high: assert property (
		issue |-> cke_reg && $past(cke_reg) && xsr_reg == '0)
		else $error("command without clock enable on two edges");
	a_power_on_reset: assert property (
		issue && all_pwr |-> is_rst ##1 cmd_o == LCB_MRW)
		else $error("only reset may leave power on");
	a_reject_flag: assert property (
		req_valid_i && bad_w |-> req_reject_o && !req_ready_o
			##1 cmd_o == LCB_NOP)
		else $error("forbidden request not refused");

endmodule
`default_nettype wire

// ---- bench/lcb_dev_model.sv ----
`include "lcb_consts.svh"
`default_nettype none
module lcb_dev_model
	import lcb_pkg::*;
(
	input wire logic			clock_i,
	input wire logic			rst_i,
	input wire lcb_cmd_t			cmd_i,
	input wire logic [`LCB_BANK_W-1:0]	bank_i,
	input wire logic			ap_i,
	input wire logic			all_i,
	input wire logic			cke_i,
	output var int				viol_o
);
	timeunit 1ns;
	timeprecision 1ns;

	// bank belief: row open flag and countdown until the bank settles
	logic [`LCB_NBANK-1:0]	open_q;
	int			cnt_q[`LCB_NBANK];
	int			mr_q, bst_q, rrd_q, xs_q;
	logic			pwr_q, cke_q, wr_q;

	// no bank is still settling
	function automatic logic quiet();
		foreach (cnt_q[i])
			if (cnt_q[i] != 0)
				return 0;
		return 1;
	endfunction

	// every bank idle and no burst running
	function automatic logic idle();
		return quiet() && open_q == '0 && bst_q == 0 && !pwr_q;
	endfunction

	// a command the present state forbids is only counted
	task automatic bad(input logic c);
		if (c)
			viol_o++;
	endtask

	// counters drop first, so a delay of n allows a command n edges on
	always @(posedge clock_i)
	begin
		if (rst_i)
		begin
			viol_o = 0;
			open_q = '0;
			pwr_q = 1;
			mr_q = 0;
			bst_q = 0;
			rrd_q = 0;
			xs_q = 0;
			cke_q = 1;
			foreach (cnt_q[i])
				cnt_q[i] = 0;
		end
		else
		begin
			foreach (cnt_q[i])
				cnt_q[i] -= int'(cnt_q[i] != 0);
			mr_q -= int'(mr_q != 0);
			bst_q -= int'(bst_q != 0);
			rrd_q -= int'(rrd_q != 0);
			xs_q -= int'(xs_q != 0);
			if (cke_i && !cke_q)
				xs_q = `LCB_TXSR_CYC;
			// self refresh entry is the one command sent as cke falls
			if (cmd_i != LCB_NOP)
				bad((!cke_i && cmd_i != LCB_SRE) || !cke_q
					|| xs_q != 0 || mr_q != 0);
			case (cmd_i)
				LCB_ACT:
				begin
					bad(pwr_q || rrd_q != 0);
					bad(open_q[bank_i] || cnt_q[bank_i] != 0);
					open_q[bank_i] = 1;
					cnt_q[bank_i] = `LCB_TRCD_CYC;
					rrd_q = `LCB_TRRD_CYC;
				end
				LCB_RD, LCB_WR:
				begin
					bad(!open_q[bank_i] || cnt_q[bank_i] != 0);
					bad(bst_q != 0 && wr_q != (cmd_i == LCB_WR));
					bst_q = `LCB_BURST_CYC;
					wr_q = (cmd_i == LCB_WR);
					// auto precharge closes the row by itself
					if (ap_i)
					begin
						open_q[bank_i] = 0;
						cnt_q[bank_i] = `LCB_BURST_CYC + `LCB_TRP_CYC
							+ (wr_q ? `LCB_TWR_CYC : 0);
					end
				end
				LCB_PRE:
				begin
					bad(all_i ? !quiet() : cnt_q[bank_i] != 0);
					foreach (cnt_q[i])
						if (all_i || i == int'(bank_i))
						begin
							open_q[i] = 0;
							cnt_q[i] = `LCB_TRP_CYC;
						end
				end
				LCB_REF_AB, LCB_SRE:
				begin
					bad(!idle());
					foreach (cnt_q[i])
						cnt_q[i] = (cmd_i == LCB_SRE) ? 0 : `LCB_TRFCAB_CYC;
				end
				LCB_MRW:
				begin
					bad(!pwr_q && !idle());
					mr_q = `LCB_TMRW_CYC;
					foreach (cnt_q[i])
						cnt_q[i] = pwr_q ? `LCB_TINIT5_CYC : cnt_q[i];
					pwr_q = 0;
				end
				LCB_MRR:
				begin
					bad(bst_q != 0);
					mr_q = `LCB_TMRR_CYC;
				end
				LCB_BST:
				begin
					bad(bst_q == 0);
					bst_q = 0;
				end
				default: ; // nop leaves every bank as it is
			endcase
			cke_q = cke_i;
		end
	end
endmodule
`default_nettype wire

// ---- bench/test_lcb_host.sv ----
`include "lcb_consts.svh"
`default_nettype none
module test_lcb_host
	import lcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic			clock_i, rst_i, req_valid_i, req_ap_i, req_all_i;
	logic			req_ready_o, req_reject_o, ap_o, all_o, cke_o, mr_busy_o;
	logic [`LCB_BANK_W-1:0]	req_bank_i, bank_o;
	lcb_cmd_t		req_cmd_i, cmd_o;
	int			viol, err_total, n_compared, t_take, a;
	int			cyc = 0;
	logic			ok;

	lcb_host dut (.clock_i(clock_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_cmd_i(req_cmd_i), .req_bank_i(req_bank_i), .req_ap_i(req_ap_i),
		.req_all_i(req_all_i), .req_ready_o(req_ready_o),
		.req_reject_o(req_reject_o), .cmd_o(cmd_o), .bank_o(bank_o),
		.ap_o(ap_o), .all_o(all_o), .cke_o(cke_o), .mr_busy_o(mr_busy_o));
	lcb_dev_model dev (.clock_i(clock_i), .rst_i(rst_i), .cmd_i(cmd_o),
		.bank_i(bank_o), .ap_i(ap_o), .all_i(all_o), .cke_i(cke_o),
		.viol_o(viol));

	// 10 MHz clock; cycle count steps on the falling edge, away from sampling
	initial
	begin
		clock_i = 0;
		forever #50 clock_i = ~clock_i;
	end
	always @(negedge clock_i)
		cyc++;

	task automatic chk(input string what, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	// request held from a falling edge until taken or refused; stays up
	// afterwards so the next request can follow back to back
	task automatic req(input lcb_cmd_t c, input int b, input logic ap, al);
		int n;
		n = 0;
		req_valid_i = 1;
		req_cmd_i = c;
		req_bank_i = 3'(b);
		req_ap_i = ap;
		req_all_i = al;
		#1;
		while (req_ready_o !== 1'b1 && req_reject_o !== 1'b1 && n < 400)
		begin
			@(negedge clock_i);
			#1;
			n++;
		end
		ok = (req_ready_o === 1'b1);
		chk("request answered", n < 400, 1);
		if (ok)
		begin
			@(posedge clock_i);
			t_take = cyc;
		end
		// always end on a falling edge so the next drive lands there
		@(negedge clock_i);
	endtask

	task automatic rel;
		req_valid_i = 0;
		req_cmd_i = LCB_NOP;
		@(negedge clock_i);
	endtask

	// length of the mode register quiet time, seen from its second cycle
	task automatic busy_len(input int n);
		int k;
		k = 0;
		while (mr_busy_o === 1'b1 && k < 50)
		begin
			k++;
			@(negedge clock_i);
		end
		chk("mode busy cycles", k, n);
	endtask

	task automatic t_power;
		chk("idle pins", cmd_o, LCB_NOP);
		chk("cke", cke_o, 1'b1);
		req(LCB_ACT, 0, 0, 0);
		chk("act at power on", ok, 0);
		req(LCB_RST, 0, 0, 0);
		chk("reset pin", cmd_o, LCB_MRW);
		rel();
		busy_len(`LCB_TMRW_CYC - 1);
		req(LCB_MRR, 0, 0, 0);
		chk("mrr resetting", cmd_o, LCB_MRR);
		rel();
		busy_len(`LCB_TMRR_CYC - 1);
		$display("test power done");
	endtask

	task automatic t_act;
		req(LCB_ACT, 2, 0, 0);
		a = t_take;
		req(LCB_ACT, 3, 0, 0);
		chk("act spacing", t_take - a, `LCB_TRRD_CYC + 1);
		req(LCB_RD, 2, 0, 0);
		chk("read pin", cmd_o, LCB_RD);
		a = t_take;
		req(LCB_ACT, 4, 0, 0);
		chk("act during burst", bank_o, 4);
		req(LCB_WR, 3, 0, 0);
		chk("write after read", t_take - a > `LCB_BURST_CYC, 1);
		a = t_take;
		req(LCB_RD, 3, 0, 0);
		chk("read after write", t_take - a > `LCB_BURST_CYC, 1);
		rel();
		$display("test act done");
	endtask

	task automatic t_bst;
		req(LCB_WR, 2, 0, 0);
		req(LCB_BST, 5, 0, 0);
		a = t_take;
		chk("bst pin", cmd_o, LCB_BST);
		chk("bst bank", bank_o, 2);
		req(LCB_RD, 2, 0, 0);
		chk("read after bst", t_take - a, 1);
		rel();
		repeat (4) @(negedge clock_i);
		req(LCB_BST, 2, 0, 0);
		chk("bst no burst", ok, 0);
		chk("reject flag", req_reject_o, 1'b1);
		req(lcb_cmd_t'(4'hF), 0, 0, 0);
		chk("unknown code", ok, 0);
		chk("no pin on refusal", cmd_o, LCB_NOP);
		rel();
		$display("test bst done");
	endtask

	task automatic t_ap;
		req(LCB_RD, 3, 1, 0);
		chk("ap pin", ap_o, 1'b1);
		a = t_take;
		req(LCB_RD, 2, 0, 0);
		chk("other bank in ap", t_take - a, 1);
		chk("no ap pin", ap_o, 1'b0);
		req(LCB_WR, 4, 1, 0);
		chk("wr ap pin", ap_o, 1'b1);
		rel();
		repeat (12) @(negedge clock_i);
		$display("test ap done");
	endtask

	task automatic t_pre;
		req(LCB_PRE, 0, 0, 1);
		chk("pre all pin", all_o, 1'b1);
		a = t_take;
		req(LCB_MRR, 1, 0, 0);
		chk("mrr precharging", t_take - a, 1);
		req(LCB_MRW, 0, 0, 0);
		chk("mrw pin", cmd_o, LCB_MRW);
		rel();
		busy_len(`LCB_TMRW_CYC - 1);
		req(LCB_REF_AB, 0, 0, 0);
		chk("refresh pin", cmd_o, LCB_REF_AB);
		req(LCB_REF_PB, 5, 0, 0);
		chk("bank refresh pin", cmd_o, LCB_REF_PB);
		chk("bank refresh bank", bank_o, 5);
		rel();
		$display("test pre done");
	endtask

	task automatic t_sr;
		req(LCB_SRX, 0, 0, 0);
		chk("exit when awake", ok, 0);
		req(LCB_SRE, 0, 0, 0);
		chk("sre pin", cmd_o, LCB_SRE);
		rel();
		chk("cke low", cke_o, 1'b0);
		req(LCB_SRX, 0, 0, 0);
		a = t_take;
		req(LCB_ACT, 1, 0, 0);
		chk("act after exit", t_take - a > `LCB_TXSR_CYC, 1);
		chk("cke high", cke_o, 1'b1);
		rel();
		$display("test sr done");
	endtask

	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog: the tests need well under 2000 cycles
	initial
	begin
		#500000;
		err_total++;
		final_report();
	end

	initial
	begin
		err_total = 0;
		n_compared = 0;
		rst_i = 1;
		req_valid_i = 0;
		req_cmd_i = LCB_NOP;
		req_bank_i = '0;
		req_ap_i = 0;
		req_all_i = 0;
		repeat (2) @(negedge clock_i);
		rst_i = 0;
		@(negedge clock_i);
		t_power();
		t_act();
		t_bst();
		t_ap();
		t_pre();
		t_sr();
		repeat (4) @(negedge clock_i);
		chk("device breaches", viol, 0);
		final_report();
	end
endmodule
`default_nettype wire
